// ---- design/drt_pkg.sv ----
// shared constants and types for the drive trip retry and start/stop control
package drt_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TIME   = 8'h04;
  localparam logic [7:0] OFS_RATE   = 8'h08;
  localparam logic [7:0] OFS_FREQ   = 8'h0C;
  localparam logic [7:0] OFS_OSEL   = 8'h10;
  localparam logic [7:0] OFS_ISEL0  = 8'h14;
  localparam logic [7:0] OFS_ISEL1  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0200;
  localparam logic [31:0] TIME_RST  = 32'h0A05_0505;
  localparam logic [31:0] RATE_RST  = 32'h0010_0010;
  localparam logic [31:0] FREQ_RST  = 32'hFFFF_8000;
  localparam logic [7:0] SEL_RETRY  = 8'h1A;
  localparam logic [7:0] SEL_SEARCH = 8'h1A;
  localparam logic [3:0] FC_OC      = 4'h1;
  localparam logic [3:0] FC_OV      = 4'h2;
  localparam logic [3:0] FC_OH_SINK = 4'h3;
  localparam logic [3:0] FC_OH_BRK  = 4'h4;
  localparam logic [3:0] FC_OH_MOT  = 4'h5;
  localparam logic [3:0] FC_OL_MOT  = 4'h6;
  localparam logic [3:0] FC_OL_DRV  = 4'h7;
  // R24: profile code map
  localparam logic [1:0] PROF_LIN   = 2'h0;
  localparam logic [1:0] PROF_WEAK  = 2'h1;
  localparam logic [1:0] PROF_STRG  = 2'h2;
  localparam logic [1:0] PROF_CURV  = 2'h3;
  localparam logic [1:0] SRCH_OFF   = 2'h0;
  localparam logic [1:0] SRCH_DIP   = 2'h1;
  localparam logic [1:0] SRCH_ALL   = 2'h2;
  localparam logic [2:0] DIP_SRCH_A = 3'h4;
  localparam logic [2:0] DIP_SRCH_B = 3'h5;
  localparam int CLK_MHZ        = 200;
  localparam int MS_CYCLES      = CLK_MHZ * 1000;
  localparam int TENTH_MS       = 100;
  localparam int FAN_MIN_MINUTES = 10;
  localparam logic [12:0] FAN_MIN_TICKS = 13'(FAN_MIN_MINUTES * 60 * 10);
  localparam int SEARCH_MAX_MS  = 1200;
  localparam logic [3:0] SEARCH_TICKS = 4'(SEARCH_MAX_MS / TENTH_MS);
  localparam logic [6:0] PCT_WEAK  = 7'd5;
  localparam logic [6:0] PCT_STRG  = 7'd10;
  localparam logic [6:0] PCT_FULLW = 7'd10;
  localparam logic [6:0] PCT_FULLS = 7'd20;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SEARCH, ST_RUN, ST_DECEL, ST_TRIP, ST_ALARM} drt_state_t;
  typedef struct packed {
    logic [18:0] pad;
    logic [2:0]  power_dip_restart_mode;
    logic        stop_mode_select;
    logic [1:0]  speed_search_mode;
    logic [1:0]  ramp_profile_select;
    logic        fan_control_mode;
    logic [3:0]  retry_count_limit;
  } drt_ctrl_t;
  typedef struct packed {
    logic [7:0] allowed_power_dip_time;
    logic [7:0] speed_search_delay;
    logic [7:0] restart_delay_time;
    logic [7:0] retry_reset_interval;
  } drt_time_t;
endpackage

// ---- design/drt_top.sv ----
// drive trip retry, fan, ramp, auto search and stop control with apb registers
//
// Functional notes
// R1: retryable trip clears itself, no alarm raised
// R2: trips beyond retry limit raise alarm
// R3: only seven fault classes may retry
// R4: retry limit zero disables retry
// R5: trip clear after reset interval from trip
// R6: retry status on output with code 26
// R7: fan off when stopped and cool
// R8: fan runs ten minutes once started
// R9: fan mode 0 always on, 1 controlled
// R10: s-curve zones 5 or 10 percent
// R11: commanded time sets linear segment only
// R12: full s shape needs 10/20 percent change
// R13: curvilinear slows above base frequency
// R14: search enable input on code 26
// R15: search at most 1.2 s, then ramp
// R16: search mode 0/1/2 plus enable input
// R17: run start waits search delay first
// R18: restarts wait the restart delay
// R19: estimate above max gives normal start
// R20: dip modes 4/5 search after dip time; code only keeps dip restart open, search needs search mode 1/2 or input 26
// R21: oc/ov during search restarts search
// R22: stop mode ramp or coast
// R23: lower reference always decelerates
// R24: profile codes 0 lin 1 weak 2 strong 3 curv
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module drt_top #(
  parameter int MS_DIV = drt_pkg::MS_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RUN_CMD,
  input  wire logic        COAST_STOP,
  input  wire logic [4:0]  DIN,
  input  wire logic        FAULT_VALID,
  input  wire logic [3:0]  FAULT_CLASS,
  input  wire logic        POWER_DIP,
  input  wire logic        TEMP_LOW,
  input  wire logic        SEARCH_LOCKED,
  input  wire logic [15:0] SPEED_EST,
  input  wire logic [15:0] FREQ_REF,
  output logic             OUTPUT_EN,
  output logic             SEARCH_ACTIVE,
  output logic             ALARM_OUT,
  output logic             RETRY_CLEAR,
  output logic [2:0]       DOUT,
  output logic             FAN_ON,
  output logic [15:0]      FREQ_OUT
);
  import drt_pkg::*;

  drt_ctrl_t   ctrl;
  drt_time_t   tim;
  logic [31:0] rate;
  logic [31:0] flim;
  logic [23:0] osel;
  logic [39:0] isel;
  drt_state_t  st;
  logic [6:0]  sync1;
  logic [6:0]  sync2;
  logic [17:0] ms_cnt;
  logic [6:0]  tenth_cnt;
  logic        ms_tick;
  logic        tenth_tick;
  logic [3:0]  retry_cnt;
  logic [7:0]  tmr;
  logic [7:0]  delay_tgt;
  logic        do_search;
  logic [3:0]  srch_tmr;
  logic        try_act;
  logic        dip_pend;
  logic [7:0]  dip_tmr;
  logic        coast_hold;
  logic [12:0] fan_tmr;
  logic [15:0] ramp_from;
  logic        run_q;

  wire run   = sync2[6];
  wire coast = sync2[5];
  wire [4:0] din = sync2[4:0];

  function automatic logic retryable(input logic [3:0] c);
    return c inside {FC_OC, FC_OV, FC_OH_SINK, FC_OH_BRK, FC_OH_MOT, FC_OL_MOT, FC_OL_DRV};
  endfunction

  function automatic logic [15:0] pct(input logic [15:0] m, input logic [6:0] p);
    return 16'((32'(m) * 32'(p)) / 32'h0000_0064);
  endfunction

  function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [15:0] move(input logic [15:0] f, input logic [15:0] t, input logic [15:0] s);
    if (f < t)
      return (t - f > s) ? f + s : t;
    else
      return (f - t > s) ? f - s : t;
  endfunction

  // step size for the selected profile
  function automatic logic [15:0] ramp_step(input logic [15:0] f, input logic [15:0] from,
                                            input logic [15:0] t, input logic [15:0] s);
    logic [15:0] zone;
    logic [15:0] full;
    logic        slow;
    zone = 16'h0000;
    full = 16'h0000;
    slow = 1'b0;
    // R10: rounded start and end zones
    if (ctrl.ramp_profile_select == PROF_WEAK || ctrl.ramp_profile_select == PROF_STRG)
    begin
      zone = pct(flim[31:16], (ctrl.ramp_profile_select == PROF_WEAK) ? PCT_WEAK : PCT_STRG);
      full = pct(flim[31:16], (ctrl.ramp_profile_select == PROF_WEAK) ? PCT_FULLW : PCT_FULLS);
      // R12: full shape only on large change
      if (absd(t, from) >= full)
        slow = (absd(f, from) < zone) || (absd(t, f) < zone);
    end
    // R13: halved step above base
    if (ctrl.ramp_profile_select == PROF_CURV && f > flim[15:0])
      slow = 1'b1;
    // R11: commanded rate kept in linear part
    return slow ? ((s > 16'h0001) ? {1'b0, s[15:1]} : 16'h0001) : s;
  endfunction

  // R14: search enable carried by selector 26
  function automatic logic search_input_on(input logic [39:0] sel, input logic [4:0] d);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++)
      hit = hit | (d[i] && sel[8*i +: 8] == SEL_SEARCH);
    return hit;
  endfunction

  // R16: search decision per start kind
  function automatic logic srch_ok(input logic dip);
    return search_input_on(isel, din) || ctrl.speed_search_mode == SRCH_ALL ||
           (ctrl.speed_search_mode == SRCH_DIP && dip);
  endfunction

  wire [15:0] tgt_ref  = (FREQ_REF > flim[31:16]) ? flim[31:16] : FREQ_REF;
  wire        fault_tk = FAULT_VALID && (st == ST_SEARCH || st == ST_RUN || st == ST_DECEL);
  wire        can_try  = ctrl.retry_count_limit != 4'h0 && retry_cnt < ctrl.retry_count_limit &&
                         retryable(FAULT_CLASS);
  wire        srch_rst = st == ST_SEARCH && (FAULT_CLASS == FC_OC || FAULT_CLASS == FC_OV);
  wire        clr_now  = st == ST_TRIP && tenth_tick && tmr >= tim.retry_reset_interval;
  wire        apb_wr   = PSEL && PENABLE && PREADY && PWRITE;
  wire        dip_srch = ctrl.power_dip_restart_mode == DIP_SRCH_A || ctrl.power_dip_restart_mode == DIP_SRCH_B;

  // pin synchroniser
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end
    else
    begin
      sync1 <= {RUN_CMD, COAST_STOP, DIN};
      sync2 <= sync1;
    end

  // millisecond and tenth-second enables
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      ms_cnt     <= 18'h00000;
      tenth_cnt  <= 7'h00;
      ms_tick    <= 1'b0;
      tenth_tick <= 1'b0;
    end
    else
    begin
      ms_tick    <= ms_cnt == 18'(MS_DIV - 1);
      ms_cnt     <= (ms_cnt == 18'(MS_DIV - 1)) ? 18'h00000 : ms_cnt + 18'h00001;
      tenth_tick <= 1'b0;
      if (ms_tick)
      begin
        tenth_tick <= tenth_cnt == 7'(TENTH_MS - 1);
        tenth_cnt  <= (tenth_cnt == 7'(TENTH_MS - 1)) ? 7'h00 : tenth_cnt + 7'h01;
      end
    end

  // apb register file
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      ctrl <= CTRL_RST;
      tim  <= TIME_RST;
      rate <= RATE_RST;
      flim <= FREQ_RST;
      osel <= 24'h000000;
      isel <= 40'h0000000000;
    end
    else if (apb_wr)
      case (PADDR)
        OFS_CTRL:  ctrl <= {19'h00000, PWDATA[12:0]};
        OFS_TIME:  tim  <= PWDATA;
        OFS_RATE:  rate <= PWDATA;
        OFS_FREQ:  flim <= PWDATA;
        OFS_OSEL:  osel <= PWDATA[23:0];
        OFS_ISEL0: isel[31:0] <= PWDATA;
        OFS_ISEL1: isel[39:32] <= PWDATA[7:0];
        default:   ;
      endcase

  // apb answer, one access cycle
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && (PADDR[1:0] != 2'h0 || PADDR > OFS_STATUS);
      if (PSEL && !PENABLE && !PWRITE)
        case (PADDR)
          OFS_CTRL:   PRDATA <= ctrl;
          OFS_TIME:   PRDATA <= tim;
          OFS_RATE:   PRDATA <= rate;
          OFS_FREQ:   PRDATA <= flim;
          OFS_OSEL:   PRDATA <= {8'h00, osel};
          OFS_ISEL0:  PRDATA <= isel[31:0];
          OFS_ISEL1:  PRDATA <= {24'h000000, isel[39:32]};
          OFS_STATUS: PRDATA <= {FREQ_OUT, 5'h00, FAN_ON, try_act, ALARM_OUT, retry_cnt, 1'b0, st};
          default:    PRDATA <= 32'h00000000;
        endcase
      else if (!PSEL)
        PRDATA <= 32'h00000000;
    end

  // power dip restart window
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      dip_pend <= 1'b0;
      dip_tmr  <= 8'h00;
    end
    else if (POWER_DIP)
    begin
      dip_pend <= 1'b1;
      dip_tmr  <= 8'h00;
    end
    else if (st == ST_DELAY)
      dip_pend <= 1'b0;
    else if (dip_pend && tenth_tick)
    begin
      dip_tmr <= dip_tmr + 8'h01;
      // R20: modes 4/5 keep the dip restart open
      if (dip_tmr >= tim.allowed_power_dip_time && !dip_srch)
        dip_pend <= 1'b0;
    end

  // main sequencer
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      st         <= ST_IDLE;
      retry_cnt  <= 4'h0;
      tmr        <= 8'h00;
      delay_tgt  <= 8'h00;
      do_search  <= 1'b0;
      srch_tmr   <= 4'h0;
      try_act    <= 1'b0;
      coast_hold <= 1'b0;
      ramp_from  <= 16'h0000;
      FREQ_OUT   <= 16'h0000;
      ALARM_OUT  <= 1'b0;
      RETRY_CLEAR <= 1'b0;
      run_q      <= 1'b0;
    end
    else
    begin
      run_q       <= run;
      RETRY_CLEAR <= 1'b0;
      if (tenth_tick)
        tmr <= (tmr == 8'hFF) ? tmr : tmr + 8'h01;
      if (coast && st != ST_TRIP && st != ST_ALARM)
      begin
        st         <= ST_IDLE;
        coast_hold <= 1'b1;
        FREQ_OUT   <= 16'h0000;
      end
      else if (fault_tk)
      begin
        tmr <= 8'h00;
        // R21: oc/ov in search restarts it
        if (srch_rst)
        begin
          srch_tmr <= 4'h0;
        end
        // R1: retry without alarm
        // R3: only eligible classes
        else if (can_try)
        begin
          st        <= ST_TRIP;
          retry_cnt <= retry_cnt + 4'h1;
          try_act   <= 1'b1;
          FREQ_OUT  <= 16'h0000;
        end
        // R2: limit exceeded latches alarm
        // R4: zero limit latches every trip except oc/ov in search
        else
        begin
          st        <= ST_ALARM;
          ALARM_OUT <= 1'b1;
          try_act   <= 1'b0;
          FREQ_OUT  <= 16'h0000;
        end
      end
      else
        case (st)
          ST_IDLE:
          begin
            if (!run)
              retry_cnt <= 4'h0;
            if (run && (!run_q || coast_hold || dip_pend))
            begin
              st         <= ST_DELAY;
              tmr        <= 8'h00;
              do_search  <= srch_ok(dip_pend);
              // R17: run start waits search delay
              // R18: dip and coast restarts wait restart delay
              delay_tgt  <= (coast_hold || dip_pend) ? tim.restart_delay_time :
                            (srch_ok(1'b0) ? tim.speed_search_delay : 8'h00);
              coast_hold <= 1'b0;
            end
          end
          ST_TRIP:
          begin
            // R5: clear only after the reset interval
            if (clr_now)
            begin
              RETRY_CLEAR <= 1'b1;
              st          <= ST_DELAY;
              tmr         <= 8'h00;
              do_search   <= srch_ok(1'b0);
              // R18: retry restart waits restart delay
              delay_tgt   <= tim.restart_delay_time;
            end
          end
          ST_DELAY:
          begin
            if (!run)
            begin
              st      <= ST_IDLE;
              try_act <= 1'b0;
            end
            else if (tmr >= delay_tgt)
            begin
              srch_tmr  <= 4'h0;
              ramp_from <= 16'h0000;
              FREQ_OUT  <= 16'h0000;
              st        <= do_search ? ST_SEARCH : ST_RUN;
              if (!do_search)
                try_act <= 1'b0;
            end
          end
          ST_SEARCH:
          begin
            if (tenth_tick)
              srch_tmr <= srch_tmr + 4'h1;
            // R15: bounded search then ramp
            if (SEARCH_LOCKED || (tenth_tick && srch_tmr == SEARCH_TICKS - 4'h1))
            begin
              st      <= ST_RUN;
              try_act <= 1'b0;
              // R19: estimate over limit gives normal start
              FREQ_OUT  <= (SPEED_EST > flim[31:16]) ? 16'h0000 : SPEED_EST;
              ramp_from <= (SPEED_EST > flim[31:16]) ? 16'h0000 : SPEED_EST;
            end
          end
          ST_RUN:
          begin
            // R22: coast or ramp on run off
            if (!run)
            begin
              st        <= ctrl.stop_mode_select ? ST_IDLE : ST_DECEL;
              ramp_from <= FREQ_OUT;
              if (ctrl.stop_mode_select)
                FREQ_OUT <= 16'h0000;
            end
            // R23: lower reference always ramps down
            else if (ms_tick)
            begin
              if (FREQ_OUT == tgt_ref)
                ramp_from <= FREQ_OUT;
              else
                FREQ_OUT <= move(FREQ_OUT, tgt_ref,
                                 ramp_step(FREQ_OUT, ramp_from, tgt_ref,
                                           (FREQ_OUT < tgt_ref) ? rate[15:0] : rate[31:16]));
            end
          end
          ST_DECEL:
          begin
            if (run)
              st <= ST_RUN;
            else if (FREQ_OUT == 16'h0000)
              st <= ST_IDLE;
            else if (ms_tick)
              FREQ_OUT <= move(FREQ_OUT, 16'h0000, ramp_step(FREQ_OUT, ramp_from, 16'h0000, rate[31:16]));
          end
          ST_ALARM:
          begin
            if (apb_wr && PADDR == OFS_STATUS && PWDATA[0])
            begin
              st        <= ST_IDLE;
              ALARM_OUT <= 1'b0;
              retry_cnt <= 4'h0;
            end
          end
          default: st <= ST_IDLE;
        endcase
    end

  // gate, search flag and routed outputs
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      OUTPUT_EN     <= 1'b0;
      SEARCH_ACTIVE <= 1'b0;
      DOUT          <= 3'h0;
    end
    else
    begin
      OUTPUT_EN     <= st == ST_SEARCH || st == ST_RUN || st == ST_DECEL;
      SEARCH_ACTIVE <= st == ST_SEARCH;
      // R6: retry status on code 26
      for (int i = 0; i < 3; i++)
        DOUT[i] <= try_act && osel[8*i +: 8] == SEL_RETRY;
    end

  // cooling fan control
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      FAN_ON  <= 1'b1;
      fan_tmr <= 13'h0000;
    end
    else
    begin
      if (FAN_ON && tenth_tick && fan_tmr < FAN_MIN_TICKS)
        fan_tmr <= fan_tmr + 13'h0001;
      // R9: mode 0 keeps the fan on
      if (!ctrl.fan_control_mode)
        FAN_ON <= 1'b1;
      // R7: stopped and cool allows off
      // R8: minimum run before off
      else if (FAN_ON && st != ST_RUN && st != ST_DECEL && st != ST_SEARCH && TEMP_LOW &&
               fan_tmr >= FAN_MIN_TICKS)
        FAN_ON <= 1'b0;
      else if (!FAN_ON && (!TEMP_LOW || st == ST_RUN))
      begin
        FAN_ON  <= 1'b1;
        fan_tmr <= 13'h0000;
      end
    end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  chk_retry_no_alarm: assert property (fault_tk && !coast && !srch_rst && can_try |=> st == ST_TRIP && !ALARM_OUT) // R1
    else $error("retryable trip did not enter retry");
  chk_limit_alarm: assert property (fault_tk && !coast && !srch_rst && retry_cnt >= ctrl.retry_count_limit |=> ALARM_OUT) // R2
    else $error("trip beyond limit raised no alarm");
  chk_class_latch: assert property (fault_tk && !coast && !srch_rst && !retryable(FAULT_CLASS) |=> st == ST_ALARM) // R3
    else $error("non retryable fault did not latch");
  chk_zero_limit: assert property (fault_tk && !coast && !srch_rst && ctrl.retry_count_limit == 4'h0 |=> st == ST_ALARM) // R4
    else $error("zero limit still retried");
  chk_reset_wait: assert property ($rose(RETRY_CLEAR) |-> $past(tmr) >= $past(tim.retry_reset_interval)) // R5
    else $error("trip cleared before interval");
  chk_try_route: assert property (try_act && osel[7:0] == SEL_RETRY |=> DOUT[0]) // R6
    else $error("retry status not routed");
  chk_fan_min: assert property ($fell(FAN_ON) |-> $past(fan_tmr) >= FAN_MIN_TICKS && $past(TEMP_LOW)) // R8
    else $error("fan stopped before minimum run");
  chk_fan_always: assert property (!ctrl.fan_control_mode |=> FAN_ON) // R9
    else $error("fan off in always-on mode");
  chk_search_bound: assert property (st == ST_SEARCH |-> srch_tmr < SEARCH_TICKS) // R15
    else $error("search exceeded its time");
  chk_over_limit: assert property (st == ST_SEARCH && !fault_tk && !coast && SEARCH_LOCKED && SPEED_EST > flim[31:16]
                                   |=> st == ST_RUN && FREQ_OUT == 16'h0000) // R19
    else $error("over limit estimate not normal start");
  chk_coast_stop: assert property (st == ST_RUN && !run && !coast && !fault_tk && ctrl.stop_mode_select
                                   |=> ##1 !OUTPUT_EN) // R22
    else $error("coast stop kept output on");

  cov_retry_restart: cover property (RETRY_CLEAR ##[1:1000] st == ST_RUN);
  cov_alarm_latch: cover property ($rose(ALARM_OUT));
  cov_search_run: cover property (st == ST_SEARCH ##1 st == ST_RUN);
endmodule // drt_top

// ---- test/drt_motor_model.sv ----
// behavioural motor and cabinet model answering speed search
`timescale 1ns/1ps
module drt_motor_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        search_on,
  input  wire logic        drive_on,
  output logic             locked,
  output logic [15:0]      speed,
  output logic             cool
);
  logic [3:0] cnt;
  // estimate qualified only by the lock pulse, scrambled otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      locked <= 1'b0;
      speed <= 16'h5A5A;
      cool <= 1'b0;
    end
    else
    begin
      cnt <= search_on ? cnt + 4'h1 : 4'h0;
      locked <= search_on && cnt == 4'hE;
      speed <= (search_on && cnt == 4'hE) ? 16'h0040 : ~speed;
      cool <= !drive_on;
    end
  end
endmodule // drt_motor_model

// ---- test/drt_top_tb_top.sv ----
// self-checking bench for retry, alarm latching, stop modes and registers
`timescale 1ns/1ps
module drt_top_tb_top;
  import drt_pkg::*;
  localparam int TICK = 1000;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] speed, fout, fref;
  logic [3:0]  fcls;
  logic [2:0]  dout;
  logic        clk, rst_n, psel, penable, pwrite, pready, perr, er;
  logic        run, fv, cst, lock, cool, oen, sact, alarm, rclr, fan;
  wire  [2:0]  mon = {rclr, alarm, oen};
  int          n_mismatch, samples_checked, cyc;

  drt_top #(.MS_DIV(10)) u_dut (.CLOCK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
    .RUN_CMD(run), .COAST_STOP(cst), .DIN(5'h00), .FAULT_VALID(fv), .FAULT_CLASS(fcls),
    .POWER_DIP(1'b0), .TEMP_LOW(cool), .SEARCH_LOCKED(lock), .SPEED_EST(speed), .FREQ_REF(fref),
    .OUTPUT_EN(oen), .SEARCH_ACTIVE(sact), .ALARM_OUT(alarm), .RETRY_CLEAR(rclr), .DOUT(dout),
    .FAN_ON(fan), .FREQ_OUT(fout));
  drt_motor_model u_motor (.clk(clk), .rst_n(rst_n), .search_on(sact), .drive_on(oen),
    .locked(lock), .speed(speed), .cool(cool));

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb ready", pready, 1'b1);
    if (pready !== 1'b1)
      give_verdict;
  endtask

  task wait_for(input int idx, input logic v, input int lim);
    cyc = 0;
    while (mon[idx] !== v && cyc <= lim)
    begin
      @(posedge clk);
      cyc++;
    end
    chk("wait", mon[idx], v);
    if (mon[idx] !== v)
      give_verdict;
  endtask

  task start_run;
    run <= 1'b1;
    wait_for(0, 1'b1, 3 * TICK);
  endtask

  task fault(input logic [3:0] c);
    @(posedge clk);
    fv <= 1'b1;
    fcls <= c;
    @(posedge clk);
    fv <= 1'b0;
  endtask

  task clear_alarm;
    run <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("alarm cleared", alarm, 1'b0);
  endtask

  task regs_reset;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, CTRL_RST);
    apb(1'b0, OFS_TIME, 32'h0);
    chk("time reset", rd, TIME_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", er, 1'b1);
    chk("fan always on", fan, 1'b1);
  endtask

  task retry_then_alarm;
    apb(1'b1, OFS_CTRL, 32'h0000_0201);
    start_run;
    fault(FC_OC);
    repeat (3) @(posedge clk);
    chk("retry status outputs", dout, 3'b101);
    wait_for(2, 1'b1, 3 * TICK);
    chk("clear after interval", cyc > 2 * TICK - 8, 1'b1);
    chk("no alarm on retry", alarm, 1'b0);
    wait_for(0, 1'b1, 3 * TICK);
    fault(FC_OV);
    wait_for(1, 1'b1, 20);
    @(posedge clk);
    chk("gate off in alarm", oen, 1'b0);
    clear_alarm;
  endtask

  task latch_case(input logic [31:0] ctrl, input logic [3:0] c);
    apb(1'b1, OFS_CTRL, ctrl);
    start_run;
    fault(c);
    wait_for(1, 1'b1, 20);
    chk("no retry clear", rclr, 1'b0);
    clear_alarm;
  endtask

  task search_start;
    apb(1'b1, OFS_CTRL, 32'h0000_0300);
    start_run;
    chk("search active", sact, 1'b1);
    repeat (20) @(posedge clk);
    chk("search ended", sact, 1'b0);
    chk("start from estimate", fout >= 16'h0040 && fout <= 16'h0050, 1'b1);
    run <= 1'b0;
    wait_for(0, 1'b0, 10);
  endtask

  task coast_restart;
    apb(1'b1, OFS_CTRL, 32'h0000_0203);
    start_run;
    cst <= 1'b1;
    wait_for(0, 1'b0, 10);
    chk("coast input stops", fout, 16'h0000);
    cst <= 1'b0;
    wait_for(0, 1'b1, 2 * TICK);
    run <= 1'b0;
    wait_for(0, 1'b0, 10);
  endtask

  task stop_modes;
    apb(1'b1, OFS_CTRL, 32'h0000_0203);
    start_run;
    repeat (200) @(posedge clk);
    chk("ramp reached ref", fout, 16'h0100);
    fref <= 16'h0080;
    repeat (4) @(posedge clk);
    chk("lower ref ramps", fout > 16'h0080 && oen, 1'b1);
    repeat (100) @(posedge clk);
    chk("lower ref reached", fout, 16'h0080);
    run <= 1'b0;
    wait_for(0, 1'b0, 10);
    chk("coast freq zero", fout, 16'h0000);
    fref <= 16'h0100;
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    start_run;
    repeat (200) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ramp stop keeps gate", oen, 1'b1);
    wait_for(0, 1'b0, 2 * TICK);
    chk("ramp stop freq zero", fout, 16'h0000);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    cst = 1'b0;
    fref = 16'h0100;
    fv = 1'b0;
    fcls = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    regs_reset;
    apb(1'b1, OFS_TIME, 32'h0100_0102);
    apb(1'b1, OFS_OSEL, 32'h001A_001A);
    retry_then_alarm;
    latch_case(32'h0000_0203, 4'h8);
    latch_case(32'h0000_0200, FC_OH_MOT);
    search_start;
    coast_restart;
    stop_modes;
    give_verdict;
  end
endmodule // drt_top_tb_top
